/* clock_standby_cfg.svh */
// constants of the clock and standby sequencer: offsets, fields, reset values, counts
`ifndef CLOCK_STANDBY_CFG_SVH
`define CLOCK_STANDBY_CFG_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define OFS_SEQ_CONTROL      8'h00
`define OFS_SEQ_STATUS       8'h01
`define OFS_ADC_MODE_TWO     8'h02

// ----------------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------------
`define SEL_LSB              0
`define SEL_MSB              1
`define CONTROL_RESET        8'h00
`define ADC_MODE_TWO_RESET   8'h00
`define SNOOZE_EN_BIT        2
`define ADC_MODE_TWO_ZERO    8'h12
`define ST_EDGE_BIT          0
`define ST_DETECT_BIT        1
`define ST_CONV_BIT          2
`define ST_SNOOZE_BIT        3
`define ST_CLK_EXT_BIT       4
`define ST_ERROR_BIT         5
`define ST_STANDBY_BIT       6

// ----------------------------------------------------------------------------
// interval timer control words and indicator patterns (active low)
// ----------------------------------------------------------------------------
`define ITC_START_SWITCH     16'h8001
`define ITC_START_SNOOZE     16'h8FFF
`define ITC_STOP             16'h0000
`define CLK_LED_ONCHIP       3'h3
`define CLK_LED_EXTERNAL     3'h6
`define CLK_LED_DARK         3'h7
`define CPU_LED_RUN          2'h0
`define CPU_LED_HALT         2'h1
`define CPU_LED_SNOOZE       2'h2
`define CPU_LED_STOP         2'h3

// ----------------------------------------------------------------------------
// idle block length
// ----------------------------------------------------------------------------
`define IDLE_BLOCK_CYCLES    512
`define IDLE_LAST            9'h1FF

`endif

/* clock_standby_pkg.sv */
// types of the clock and standby sequencer
`default_nettype none

package clock_standby_pkg;

  typedef enum logic [1:0] {
    SEL_HALT,
    SEL_STOP,
    SEL_SNOOZE,
    SEL_CLOCK
  } transition_sel_t;

  typedef enum logic [4:0] {
    S_INIT,
    S_RUN_CLR,
    S_RUN_WAIT,
    S_HALT_ENT,
    S_HALT,
    S_STOP_ENT,
    S_STOP,
    S_WAKE,
    S_SNZ_MASK,
    S_SNZ_ADC,
    S_SNZ_TIMER,
    S_GO_EXT,
    S_SW_START,
    S_SW_POLL,
    S_SW_STOP,
    S_SW_DONE,
    S_ERROR
  } seq_state_t;

endpackage : clock_standby_pkg

`default_nettype wire

/* idle_block_counter.sv */
// counter that times one block of idle cycles in the run loop
`default_nettype none
`include "clock_standby_cfg.svh"

module idle_block_counter (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  // control
  input  wire logic       i_start,
  output logic            o_done
);

  logic       run_ff;
  logic [8:0] cnt_ff;

  // start restarts a block even if one is running
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      run_ff <= 1'b0;
      cnt_ff <= 9'h000;
    end else if (i_start) begin
      run_ff <= 1'b1;
      cnt_ff <= 9'h000;
    end else if (run_ff) begin
      run_ff <= (cnt_ff != `IDLE_LAST);
      cnt_ff <= cnt_ff + 9'h001;
    end
  end

  assign o_done = run_ff && (cnt_ff == `IDLE_LAST);

endmodule : idle_block_counter

`default_nettype wire

/* clock_standby_sequencer.sv */
// clock and standby mode sequencer with its register port
// What this block does
// - after reset light clock LED5, darken LED3 and LED4, light both CPU LEDs
// - run loop clears detection flag, then repeats 512-cycle idle blocks until flag set
// - each step clears edge request flag in the same cycle as its indicators, before next run or standby state
// - HALT entry from on-chip run darkens LED1 and lights LED2
// - STOP entry darkens both CPU LEDs, clears edge flag, enters STOP
// - release from HALT or STOP lights both CPU LEDs, clears flag, resumes run loop
// - external to on-chip switch starts timer with 8001H, polls main clock status for 0
// - interval timer event before status reaches 0 abandons switch into error
// - after switch success mask interval irq, stop timer 0000H, stop crystal oscillator
// - switch completion shows on-chip clock, lights CPU LEDs, clears flag, unmasks edge irq
// - SNOOZE entry masks edge irq before converter setup
// - SNOOZE setup makes interval timer irq trigger conversions in hardware
// - SNOOZE entry masks interval irq, LED1 lit LED2 dark, timer 8FFFH, then STOP
// - converter setup clears done flag, unmasks done irq, then sets snooze enable
// - snooze enable is bit 2 of mode register two; bits 4 and 1 stay 0
`default_nettype none
`include "clock_standby_cfg.svh"

module clock_standby_sequencer (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  // events
  input  wire logic        i_switch_edge_irq,
  input  wire logic        i_interval_timer_irq,
  input  wire logic        i_main_clock_status,
  input  wire logic        i_conversion_done,
  // indicators, active low
  output logic      [1:0]  o_cpu_led_n,
  output logic      [2:0]  o_clk_led_n,
  // peripheral controls
  output logic             o_ext_edge_irq_mask,
  output logic             o_interval_irq_mask,
  output logic      [15:0] o_interval_timer_control,
  output logic             o_crystal_osc_stop,
  output logic             o_conversion_irq_mask,
  output logic             o_adc_hw_trigger,
  output logic      [7:0]  o_converter_mode_reg_two,
  output logic             o_error
);

  // --------------------------------------------------------------------------
  // state and storage
  // --------------------------------------------------------------------------
  clock_standby_pkg::seq_state_t state_ff;
  clock_standby_pkg::seq_state_t nxt_state;
  logic [7:0]  control_ff;
  logic [7:0]  mode_two_ff;
  logic [7:0]  rdata_ff;
  logic [1:0]  cpu_led_ff;
  logic [2:0]  clk_led_ff;
  logic [15:0] itc_ff;
  logic        edge_flag_ff, detect_ff, conv_flag_ff;
  logic        edge_mask_ff, int_mask_ff, osc_stop_ff, conv_mask_ff;
  logic        hw_trig_ff, snooze_ff, clk_ext_ff;
  logic        idle_done, idle_start, edge_clr, wake_ok;
  clock_standby_pkg::transition_sel_t sel;

  function automatic logic clears_edge(input clock_standby_pkg::seq_state_t st);
    case (st)
      clock_standby_pkg::S_INIT,
      clock_standby_pkg::S_HALT_ENT,
      clock_standby_pkg::S_STOP_ENT,
      clock_standby_pkg::S_WAKE,
      clock_standby_pkg::S_SNZ_TIMER,
      clock_standby_pkg::S_GO_EXT,
      clock_standby_pkg::S_SW_DONE: clears_edge = 1'b1;
      default:                      clears_edge = 1'b0;
    endcase
  endfunction : clears_edge

  // --------------------------------------------------------------------------
  // decoding
  // --------------------------------------------------------------------------
  wire wr_ctrl = i_wr && (i_addr == `OFS_SEQ_CONTROL);
  wire wr_mode = i_wr && (i_addr == `OFS_ADC_MODE_TWO);
  wire in_standby = (state_ff == clock_standby_pkg::S_HALT) ||
                    (state_ff == clock_standby_pkg::S_STOP);
  wire [7:0] status_word = {1'b0, in_standby, (state_ff == clock_standby_pkg::S_ERROR),
                            clk_ext_ff, snooze_ff, conv_flag_ff, detect_ff, edge_flag_ff};
  assign sel = clock_standby_pkg::transition_sel_t'(control_ff[`SEL_MSB:`SEL_LSB]);
  assign edge_clr = clears_edge(state_ff);
  // wake needs an unmasked switch edge; snooze also wakes on a finished conversion
  assign wake_ok = (edge_flag_ff && !edge_mask_ff) || (snooze_ff && i_conversion_done);
  assign idle_start = (state_ff == clock_standby_pkg::S_RUN_CLR) ||
                      ((state_ff == clock_standby_pkg::S_RUN_WAIT) && idle_done
                       && !detect_ff);
  idle_block_counter u_idle (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_start   (idle_start),
    .o_done    (idle_done)
  );

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      clock_standby_pkg::S_INIT:      nxt_state = clock_standby_pkg::S_RUN_CLR;
      clock_standby_pkg::S_RUN_CLR:   nxt_state = clock_standby_pkg::S_RUN_WAIT;
      clock_standby_pkg::S_RUN_WAIT: begin
        if (idle_done && detect_ff) begin
          case (sel)
            clock_standby_pkg::SEL_HALT: nxt_state = clock_standby_pkg::S_HALT_ENT;
            clock_standby_pkg::SEL_STOP: nxt_state = clock_standby_pkg::S_STOP_ENT;
            clock_standby_pkg::SEL_SNOOZE:
              nxt_state = clk_ext_ff ? clock_standby_pkg::S_SW_START
                                     : clock_standby_pkg::S_SNZ_MASK;
            default:
              nxt_state = clk_ext_ff ? clock_standby_pkg::S_SW_START
                                     : clock_standby_pkg::S_GO_EXT;
          endcase
        end
      end
      clock_standby_pkg::S_HALT_ENT:  nxt_state = clock_standby_pkg::S_HALT;
      clock_standby_pkg::S_STOP_ENT:  nxt_state = clock_standby_pkg::S_STOP;
      clock_standby_pkg::S_HALT,
      clock_standby_pkg::S_STOP: if (wake_ok) nxt_state = clock_standby_pkg::S_WAKE;
      clock_standby_pkg::S_WAKE:      nxt_state = clock_standby_pkg::S_RUN_CLR;
      clock_standby_pkg::S_SNZ_MASK:  nxt_state = clock_standby_pkg::S_SNZ_ADC;
      clock_standby_pkg::S_SNZ_ADC:   nxt_state = clock_standby_pkg::S_SNZ_TIMER;
      clock_standby_pkg::S_SNZ_TIMER: nxt_state = clock_standby_pkg::S_STOP;
      clock_standby_pkg::S_GO_EXT:    nxt_state = clock_standby_pkg::S_RUN_CLR;
      clock_standby_pkg::S_SW_START:  nxt_state = clock_standby_pkg::S_SW_POLL;
      clock_standby_pkg::S_SW_POLL: begin
        // status is looked at first, so a same-cycle timer event still succeeds
        if (!i_main_clock_status) begin
          nxt_state = clock_standby_pkg::S_SW_STOP;
        end else if (i_interval_timer_irq) begin
          nxt_state = clock_standby_pkg::S_ERROR;
        end
      end
      clock_standby_pkg::S_SW_STOP:   nxt_state = clock_standby_pkg::S_SW_DONE;
      clock_standby_pkg::S_SW_DONE:   nxt_state = clock_standby_pkg::S_RUN_CLR;
      clock_standby_pkg::S_ERROR:     nxt_state = clock_standby_pkg::S_ERROR;
      default:                        nxt_state = clock_standby_pkg::S_ERROR;
    endcase
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) state_ff <= clock_standby_pkg::S_INIT;
    else            state_ff <= nxt_state;
  end

  // --------------------------------------------------------------------------
  // event flags: a set in the clearing cycle wins
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      edge_flag_ff <= 1'b0;
      detect_ff    <= 1'b0;
      conv_flag_ff <= 1'b0;
    end else begin
      edge_flag_ff <= i_switch_edge_irq || (edge_flag_ff && !edge_clr);
      detect_ff    <= (i_switch_edge_irq && !edge_mask_ff) ||
                      (detect_ff && (state_ff != clock_standby_pkg::S_RUN_CLR));
      conv_flag_ff <= i_conversion_done ||
                      (conv_flag_ff && (state_ff != clock_standby_pkg::S_SNZ_ADC));
    end
  end

  // --------------------------------------------------------------------------
  // indicators
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cpu_led_ff <= `CPU_LED_STOP;
      clk_led_ff <= `CLK_LED_DARK;
    end else begin
      case (state_ff)
        clock_standby_pkg::S_INIT: begin
          cpu_led_ff <= `CPU_LED_RUN;
          clk_led_ff <= `CLK_LED_ONCHIP;
        end
        clock_standby_pkg::S_HALT_ENT:  cpu_led_ff <= `CPU_LED_HALT;
        clock_standby_pkg::S_STOP_ENT:  cpu_led_ff <= `CPU_LED_STOP;
        clock_standby_pkg::S_WAKE:      cpu_led_ff <= `CPU_LED_RUN;
        clock_standby_pkg::S_SNZ_TIMER: cpu_led_ff <= `CPU_LED_SNOOZE;
        clock_standby_pkg::S_GO_EXT: begin
          cpu_led_ff <= `CPU_LED_RUN;
          clk_led_ff <= `CLK_LED_EXTERNAL;
        end
        clock_standby_pkg::S_SW_DONE: begin
          cpu_led_ff <= `CPU_LED_RUN;
          clk_led_ff <= `CLK_LED_ONCHIP;
        end
        clock_standby_pkg::S_ERROR: begin
          cpu_led_ff <= `CPU_LED_STOP;
          clk_led_ff <= `CLK_LED_DARK;
        end
        default:                        cpu_led_ff <= cpu_led_ff;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // interval timer, masks and oscillator
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      itc_ff       <= `ITC_STOP;
      int_mask_ff  <= 1'b1;
      edge_mask_ff <= 1'b0;
      osc_stop_ff  <= 1'b1;
      clk_ext_ff   <= 1'b0;
    end else begin
      case (state_ff)
        clock_standby_pkg::S_SNZ_MASK:  edge_mask_ff <= 1'b1;
        clock_standby_pkg::S_SNZ_TIMER: begin
          int_mask_ff <= 1'b1;
          itc_ff      <= `ITC_START_SNOOZE;
        end
        clock_standby_pkg::S_WAKE: begin
          if (snooze_ff) begin
            itc_ff       <= `ITC_STOP;
            edge_mask_ff <= 1'b0;
          end
        end
        clock_standby_pkg::S_GO_EXT: begin
          osc_stop_ff <= 1'b0;
          clk_ext_ff  <= 1'b1;
        end
        clock_standby_pkg::S_SW_START: begin
          itc_ff      <= `ITC_START_SWITCH;
          int_mask_ff <= 1'b0;
        end
        clock_standby_pkg::S_SW_STOP: begin
          int_mask_ff <= 1'b1;
          itc_ff      <= `ITC_STOP;
          osc_stop_ff <= 1'b1;
        end
        clock_standby_pkg::S_SW_DONE: begin
          edge_mask_ff <= 1'b0;
          clk_ext_ff   <= 1'b0;
        end
        clock_standby_pkg::S_ERROR:     itc_ff <= `ITC_STOP;
        default:                        itc_ff <= itc_ff;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // converter setup and registers
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      conv_mask_ff <= 1'b1;
      hw_trig_ff   <= 1'b0;
      snooze_ff    <= 1'b0;
    end else if (state_ff == clock_standby_pkg::S_SNZ_ADC) begin
      conv_mask_ff <= 1'b0;
      hw_trig_ff   <= 1'b1;
    end else if (state_ff == clock_standby_pkg::S_SNZ_TIMER) begin
      snooze_ff    <= 1'b1;
    end else if ((state_ff == clock_standby_pkg::S_WAKE) && snooze_ff) begin
      snooze_ff    <= 1'b0;
      hw_trig_ff   <= 1'b0;
      conv_mask_ff <= 1'b1;
    end
  end

  // sequencer writes to mode register two win over software writes
  wire [7:0] mode_sw  = wr_mode ? i_wdata : mode_two_ff;
  wire       snz_set  = (state_ff == clock_standby_pkg::S_SNZ_TIMER);
  wire       snz_clr  = (state_ff == clock_standby_pkg::S_WAKE) && snooze_ff;
  wire [7:0] mode_bit = 8'h01 << `SNOOZE_EN_BIT;
  wire [7:0] mode_seq = snz_set ? (mode_sw | mode_bit)
                      : snz_clr ? (mode_sw & ~mode_bit) : mode_sw;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      control_ff  <= `CONTROL_RESET;
      mode_two_ff <= `ADC_MODE_TWO_RESET;
      rdata_ff    <= 8'h00;
    end else begin
      if (wr_ctrl) control_ff <= i_wdata;
      mode_two_ff <= mode_seq & ~`ADC_MODE_TWO_ZERO;
      if (!i_rd)                                 rdata_ff <= 8'h00;
      else if (i_addr == `OFS_SEQ_CONTROL)       rdata_ff <= control_ff;
      else if (i_addr == `OFS_SEQ_STATUS)        rdata_ff <= status_word;
      else if (i_addr == `OFS_ADC_MODE_TWO)      rdata_ff <= mode_two_ff;
      else                                       rdata_ff <= 8'h00;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign o_rdata                  = rdata_ff;
  assign o_cpu_led_n              = cpu_led_ff;
  assign o_clk_led_n              = clk_led_ff;
  assign o_ext_edge_irq_mask      = edge_mask_ff;
  assign o_interval_irq_mask      = int_mask_ff;
  assign o_interval_timer_control = itc_ff;
  assign o_crystal_osc_stop       = osc_stop_ff;
  assign o_conversion_irq_mask    = conv_mask_ff;
  assign o_adc_hw_trigger         = hw_trig_ff;
  assign o_converter_mode_reg_two = mode_two_ff;
  assign o_error                  = (state_ff == clock_standby_pkg::S_ERROR);

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence halt_entry_s;
    state_ff == clock_standby_pkg::S_HALT_ENT && !clk_ext_ff;
  endsequence
  sequence snooze_steps_s;
    state_ff == clock_standby_pkg::S_SNZ_MASK ##1 state_ff == clock_standby_pkg::S_SNZ_ADC
    ##1 state_ff == clock_standby_pkg::S_SNZ_TIMER;
  endsequence
  reset_leds_a: assert property ($rose(state_ff == clock_standby_pkg::S_RUN_CLR) &&
      $past(state_ff) == clock_standby_pkg::S_INIT |->
      o_clk_led_n == `CLK_LED_ONCHIP && o_cpu_led_n == `CPU_LED_RUN)
    else $error("reset indicators wrong");
  run_loop_a: assert property (state_ff == clock_standby_pkg::S_RUN_WAIT && idle_done &&
      !detect_ff |=> state_ff == clock_standby_pkg::S_RUN_WAIT)
    else $error("run loop left without detection");
  edge_clear_a: assert property (edge_clr && !i_switch_edge_irq |=> !edge_flag_ff)
    else $error("edge flag not cleared");
  halt_leds_a: assert property (halt_entry_s |=>
      o_cpu_led_n == `CPU_LED_HALT && state_ff == clock_standby_pkg::S_HALT)
    else $error("halt indicators wrong");
  stop_leds_a: assert property (state_ff == clock_standby_pkg::S_STOP_ENT |=>
      o_cpu_led_n == `CPU_LED_STOP && state_ff == clock_standby_pkg::S_STOP)
    else $error("stop indicators wrong");
  wake_leds_a: assert property (in_standby && wake_ok |=> ##1
      o_cpu_led_n == `CPU_LED_RUN && state_ff == clock_standby_pkg::S_RUN_CLR)
    else $error("wake indicators wrong");
  switch_start_a: assert property (state_ff == clock_standby_pkg::S_SW_START |=>
      o_interval_timer_control == `ITC_START_SWITCH)
    else $error("timer not started for switch");
  switch_err_a: assert property (state_ff == clock_standby_pkg::S_SW_POLL &&
      i_main_clock_status && i_interval_timer_irq |=> o_error [*3])
    else $error("switch error not taken");
  switch_stop_a: assert property (state_ff == clock_standby_pkg::S_SW_STOP |=>
      o_interval_irq_mask && o_interval_timer_control == `ITC_STOP && o_crystal_osc_stop)
    else $error("switch stop wrong");
  switch_done_a: assert property (state_ff == clock_standby_pkg::S_SW_DONE |=>
      o_clk_led_n == `CLK_LED_ONCHIP && !o_ext_edge_irq_mask)
    else $error("switch completion wrong");
  snooze_mask_a: assert property (snooze_steps_s |-> $past(o_ext_edge_irq_mask) &&
      !$past(o_adc_hw_trigger) && o_adc_hw_trigger)
    else $error("edge irq not masked first");
  snooze_trig_a: assert property (snooze_steps_s |=> o_adc_hw_trigger &&
      !o_conversion_irq_mask && o_converter_mode_reg_two[`SNOOZE_EN_BIT])
    else $error("snooze setup wrong");
  snooze_stop_a: assert property (snooze_steps_s |=> o_cpu_led_n == `CPU_LED_SNOOZE &&
      o_interval_timer_control == `ITC_START_SNOOZE && state_ff == clock_standby_pkg::S_STOP)
    else $error("snooze entry wrong");
  mode_zero_a: assert property ((o_converter_mode_reg_two & `ADC_MODE_TWO_ZERO) == 8'h00)
    else $error("held bits of mode register set");
  error_hold_a: assert property (o_error |=> o_error && o_cpu_led_n == `CPU_LED_STOP &&
      o_clk_led_n == `CLK_LED_DARK)
    else $error("error state not held");

endmodule : clock_standby_sequencer
`default_nettype wire

/* far_side_model.sv */
// far-side model: interval timer, main clock status and converter events
`default_nettype none

module far_side_model (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // from the sequencer, and i_stuck from the bench
  input  wire logic [15:0] i_timer_ctl,
  input  wire logic        i_hw_trigger,
  input  wire logic        i_osc_stop,
  input  wire logic        i_stuck,
  // to the sequencer
  output logic             o_timer_irq,
  output logic             o_clock_status,
  output logic             o_conv_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] tick_ff;
  logic [2:0] lock_ff;
  logic       ext_ff;

  // timer event every 20 cycles; clock locks after 5, or never when stuck
  assign o_timer_irq    = i_timer_ctl[15] && (tick_ff == 5'h13);
  assign o_clock_status = ext_ff | i_stuck;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_ff     <= 5'h00;
      lock_ff     <= 3'h0;
      ext_ff      <= 1'b0;
      o_conv_done <= 1'b0;
    end else begin
      tick_ff     <= (i_timer_ctl[15] && tick_ff != 5'h13) ? tick_ff + 5'h01 : 5'h00;
      o_conv_done <= o_timer_irq & i_hw_trigger;
      lock_ff     <= (i_timer_ctl == 16'h8001) ? lock_ff + 3'h1 : 3'h0;
      if (lock_ff == 3'h5)
        ext_ff <= 1'b0;
      // crystal runs only while no switch-back is in flight
      else if (!i_osc_stop && !i_timer_ctl[15])
        ext_ff <= 1'b1;
    end
  end
endmodule : far_side_model

`default_nettype wire

/* test_clock_standby_sequencer.sv */
// self-checking bench of the clock and standby sequencer
`default_nettype none

module test_clock_standby_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [7:0]  i_wdata = 8'h00;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_sw = 1'b0;
  logic        stuck = 1'b0;
  logic        seen_start = 1'b0;
  logic [7:0]  o_rdata, d, o_mode2;
  logic [1:0]  o_cpu_led_n;
  logic [2:0]  o_clk_led_n;
  logic [15:0] o_itc;
  logic        o_emask, o_imask, o_ostop, o_cmask, o_trig, o_err, t_irq, c_stat, c_done;
  int          fails = 0;
  int          compares = 0;
  int          cycles = 0;

  clock_standby_sequencer uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_switch_edge_irq(i_sw), .i_interval_timer_irq(t_irq), .i_main_clock_status(c_stat),
    .i_conversion_done(c_done), .o_cpu_led_n(o_cpu_led_n), .o_clk_led_n(o_clk_led_n),
    .o_ext_edge_irq_mask(o_emask), .o_interval_irq_mask(o_imask),
    .o_interval_timer_control(o_itc), .o_crystal_osc_stop(o_ostop),
    .o_conversion_irq_mask(o_cmask), .o_adc_hw_trigger(o_trig),
    .o_converter_mode_reg_two(o_mode2), .o_error(o_err));
  far_side_model model (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_timer_ctl(o_itc),
    .i_hw_trigger(o_trig), .i_osc_stop(o_ostop), .i_stuck(stuck), .o_timer_irq(t_irq),
    .o_clock_status(c_stat), .o_conv_done(c_done));

  // ---------------------------------------------------------------------------
  // clock, watchdog and helpers
  // ---------------------------------------------------------------------------
  always #20 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (o_itc === 16'h8001)
      seen_start <= 1'b1;
    if (cycles == 20000) begin
      fails = fails + 1;
      end_of_test;
    end
  end

  task automatic end_of_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1 v = o_rdata;
  endtask : rd

  task automatic pulse;
    @(posedge i_clk);
    i_sw <= 1'b1;
    @(posedge i_clk);
    i_sw <= 1'b0;
  endtask : pulse

  // led pattern {clock, cpu}; a transition waits at most 600 cycles
  task automatic wait_for(input logic [4:0] exp);
    int n;
    n = 0;
    while ({o_clk_led_n, o_cpu_led_n} !== exp && n < 600) begin
      @(posedge i_clk);
      #1 n++;
    end
    check(16'({o_clk_led_n, o_cpu_led_n}), 16'(exp));
  endtask : wait_for

  task automatic step(input logic [1:0] sel, input logic [4:0] exp);
    wr(8'h00, {6'h00, sel});
    pulse;
    wait_for(exp);
  endtask : step

  initial begin
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1 check(16'({o_emask, o_imask, o_ostop, o_cmask, o_clk_led_n, o_cpu_led_n}), 16'h00EC);
    repeat (600) @(posedge i_clk);
    wait_for(5'h0C);
    wr(8'h02, 8'hFF);
    rd(8'h02, d);
    check(16'(d), 16'h00ED);
    rd(8'h09, d);
    check(16'(d), 16'h0000);
    wr(8'h02, 8'h00);
    step(2'h0, 5'h0D);
    rd(8'h01, d);
    check(16'(d), 16'h0042);
    pulse;
    wait_for(5'h0C);
    step(2'h1, 5'h0F);
    pulse;
    wait_for(5'h0C);
    step(2'h2, 5'h0E);
    check(16'({o_emask, o_imask, o_trig, o_cmask}), 16'h000E);
    check(o_itc, 16'h8FFF);
    rd(8'h02, d);
    check(16'(d), 16'h0004);
    check(16'(o_mode2), 16'h0004);
    wait_for(5'h0C);
    check(16'({o_trig, o_cmask, o_emask, o_mode2[2]}), 16'h0004);
    step(2'h3, 5'h18);
    step(2'h3, 5'h0C);
    check(16'({seen_start, o_imask, o_ostop, o_emask}), 16'h000E);
    check(o_itc, 16'h0000);
    step(2'h3, 5'h18);
    @(posedge i_clk);
    stuck <= 1'b1;
    step(2'h3, 5'h1F);
    check(16'(o_err), 16'h0001);
    pulse;
    repeat (600) @(posedge i_clk);
    #1 check(16'({o_err, o_clk_led_n, o_cpu_led_n}), 16'h003F);
    end_of_test;
  end
endmodule : test_clock_standby_sequencer

`default_nettype wire
